// ### rtl/serial_defines.vh
// register map, field positions, reset values and frame constants of the serial transceiver
// assumes a 32-bit ahb-lite bus; only haddr[4:0] is decoded
`ifndef SERIAL_DEFINES_VH
`define SERIAL_DEFINES_VH
`define OFS_STATUS   5'h00
`define OFS_CTRL_ONE 5'h04
`define OFS_CTRL_TWO 5'h08
`define OFS_DIVISOR  5'h0C
`define OFS_DATA     5'h10
// uart_status_flags
`define ST_TXE  0
`define ST_TIDL 1
`define ST_RXA  2
`define ST_RIDL 3
`define ST_OVR  4
`define ST_FRM  5
`define ST_NSE  6
`define ST_PAR  7
// uart_control_one
`define C1_TX8  0
`define C1_RX8  1
`define C1_BRK  2
`define C1_STP  3
`define C1_ODD  4
`define C1_PEN  5
`define C1_DLS  6
`define C1_GEN  7
// uart_control_two
`define C2_TEIE 0
`define C2_TIIE 1
`define C2_RIE  2
`define C2_ADEN 4
`define C2_HSPD 5
`define C2_RECEIVER_ENABLE 6
`define C2_TRANSMITTER_ENABLE 7
`define RST_CTRL_ONE 8'h00
`define RST_CTRL_TWO 8'h00
`define RST_DIVISOR  8'h00
`define RST_STATUS   8'h0B
`define OVERSAMPLE_LAST 4'hF
`define SLOW_PRESCALE   2'h3
`define BREAK_BITS      4'hD
`endif

// ### rtl/async_serial_uart.v
// full-duplex asynchronous serial transceiver with ahb-lite register slave
// assumes hclk at 25 MHz, rx_in asynchronous to hclk, a zero-wait ahb-lite master
// Function
// - characters carry eight or nine data bits; transmit and receive run independently
// - even, odd or no parity, then one or two stop bits
// - both directions timed from a baud generator with 8-bit prescaler
// - received characters queue in a two-entry fifo before the data register
// - tx or rx pin returns to general i/o when its enable is zero
// - enabled uart drives tx as output, rx as input, pull-up off
// - written character moves to hidden shifter and leaves lsb first
// - rx bits shift in lsb first, full character moves to receive data
// - one address: writes feed transmit, reads return received data
// - status flags are read-only; writes leave them alone
// - tx empty sets on shifter load, clears on status read then data write
// - setting transmitter enable sets tx empty
// - tx idle zero while sending, set when empty and nothing sent
// - tx idle stays clear while data or break is queued
// - rx available sets on new data; receive irq enable raises interrupt
// - noise, framing, parity flags set in the same cycle as the transfer
// - rx available clears on status read, data read, and empty fifo
// - receiver idle is zero from start bit until the stop bit is sampled
// - overrun sets on full buffer, blocks transfers, clears by status/data sequence
// - framing error flag set on bad frame, cleared by status/data sequence
// - noise flag set with rx available, never on overrun, same clearing
// - one interrupt from tx empty, tx idle, rx full, overrun
// - parity error flag set on wrong parity when parity enabled
// - clearing global enable flushes, resets counter, tx/rx enables, break, errors; sets idles
// - length select picks 8 or 9 bits; ninth bits live in control bits
// - break holds tx low at least 13 bit times and until cleared
`timescale 1ns/10ps
`include "serial_defines.vh"
module async_serial_uart (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        rx_in,
    output reg         tx_out,
    output reg         tx_oe_n,
    output reg         tx_owned,
    output reg         rx_owned,
    output reg         rx_pullup_off,
    output reg         irq
);
    // frame image for the transmit shifter, lsb leaves first
    function [11:0] frame_fn;
        input [8:0] d;
        input       nine;
        input       pen;
        input       odd;
        begin
            frame_fn = 12'hFFF;
            frame_fn[8:0] = {d[7:0], 1'b0};
            if (nine) begin
                frame_fn[9] = d[8];
            end
            if (pen) begin
                frame_fn[4'h9 + {3'h0, nine}] = ^(nine ? d : {1'b0, d[7:0]}) ^ odd;
            end
        end
    endfunction

    reg  [7:0]  ctrl_one_q;
    reg  [7:0]  ctrl_two_q;
    reg  [7:0]  divisor_q;
    reg  [7:0]  status_q;
    reg  [7:0]  armed_q;
    reg  [7:0]  thr_q;
    reg         thr_full_q;
    reg  [4:0]  addr_q;
    reg         wr_q;
    wire        gen   = ctrl_one_q[`C1_GEN];
    wire        nine  = ctrl_one_q[`C1_DLS];
    wire        txon  = gen & ctrl_two_q[`C2_TRANSMITTER_ENABLE];
    wire        rxon  = gen & ctrl_two_q[`C2_RECEIVER_ENABLE];
    wire        acc   = hsel & htrans[1] & hready;
    wire        rd_st = acc & ~hwrite & (haddr[4:0] == `OFS_STATUS);
    wire        rd_dt = acc & ~hwrite & (haddr[4:0] == `OFS_DATA);
    wire        wr_dt = wr_q & (addr_q == `OFS_DATA);
    // baud generator: prescaler, then a further /4 unless high speed
    reg  [7:0]  bcnt_q;
    reg  [1:0]  slow_q;
    reg         tick_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bcnt_q <= 8'h00;
            slow_q <= 2'h0;
            tick_q <= 1'b0;
        end else if (!gen) begin
            bcnt_q <= 8'h00;
            slow_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (bcnt_q >= divisor_q) begin
                bcnt_q <= 8'h00;
                slow_q <= slow_q + 2'h1;
                tick_q <= ctrl_two_q[`C2_HSPD] | (slow_q == `SLOW_PRESCALE);
            end else begin
                bcnt_q <= bcnt_q + 8'h01;
            end
        end
    end
    reg  [11:0] tsh_q;
    reg  [3:0]  tleft_q;
    reg  [3:0]  tph_q;
    reg         tbusy_q;
    reg         brk_q;
    reg  [3:0]  brkn_q;
    wire        tload = txon & thr_full_q & ~tbusy_q & ~brk_q;
    wire        brk_go = txon & ctrl_one_q[`C1_BRK] & ~thr_full_q & ~tbusy_q & ~brk_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tsh_q   <= 12'hFFF;
            tleft_q <= 4'h0;
            tph_q   <= 4'h0;
            tbusy_q <= 1'b0;
            brk_q   <= 1'b0;
            brkn_q  <= 4'h0;
        end else if (!txon) begin
            tsh_q   <= 12'hFFF;
            tbusy_q <= 1'b0;
            brk_q   <= 1'b0;
        end else if (tload) begin
            tsh_q   <= frame_fn({ctrl_one_q[`C1_TX8], thr_q}, nine,
                                ctrl_one_q[`C1_PEN], ctrl_one_q[`C1_ODD]);
            tleft_q <= 4'hA + {3'h0, nine} + {3'h0, ctrl_one_q[`C1_PEN]} +
                       {3'h0, ctrl_one_q[`C1_STP]};
            tph_q   <= 4'h0;
            tbusy_q <= 1'b1;
        end else if (brk_go) begin
            brk_q  <= 1'b1;
            brkn_q <= 4'h0;
            tph_q  <= 4'h0;
        end else if (tick_q) begin
            tph_q <= tph_q + 4'h1;
            if (tph_q == `OVERSAMPLE_LAST) begin
                if (tbusy_q) begin
                    tsh_q   <= {1'b1, tsh_q[11:1]};
                    tleft_q <= tleft_q - 4'h1;
                    tbusy_q <= (tleft_q != 4'h1);
                end else if (brk_q) begin
                    if (brkn_q != `BREAK_BITS) begin
                        brkn_q <= brkn_q + 4'h1;
                    end else if (!ctrl_one_q[`C1_BRK]) begin
                        brk_q <= 1'b0;
                    end
                end
            end
        end
    end
    reg         rs1_q;
    reg         rs2_q;
    reg         rbusy_q;
    reg  [3:0]  rph_q;
    reg  [3:0]  rbit_q;
    reg  [1:0]  smp_q;
    reg  [8:0]  rsh_q;
    reg         rpar_q;
    reg         rnz_q;
    reg         rdone_q;
    reg         rfe_q;
    wire        maj = (smp_q[0] & smp_q[1]) | (rs2_q & (smp_q[0] | smp_q[1]));
    wire        dis = smp_q[0] ^ smp_q[1] | smp_q[0] ^ rs2_q;
    wire [3:0]  nd  = nine ? 4'h9 : 4'h8;
    wire [3:0]  plast = nd + {3'h0, ctrl_one_q[`C1_PEN]};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rs1_q <= 1'b1;
            rs2_q <= 1'b1;
        end else begin
            rs1_q <= rx_in;
            rs2_q <= rs1_q;
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rbusy_q <= 1'b0;
            rph_q   <= 4'h0;
            rbit_q  <= 4'h0;
            smp_q   <= 2'h0;
            rsh_q   <= 9'h000;
            rpar_q  <= 1'b0;
            rnz_q   <= 1'b0;
            rdone_q <= 1'b0;
            rfe_q   <= 1'b0;
        end else begin
            rdone_q <= 1'b0;
            if (!rxon) begin
                rbusy_q <= 1'b0;
            end else if (!rbusy_q) begin
                if (!rs2_q) begin
                    rbusy_q <= 1'b1;
                    rph_q   <= 4'h0;
                    rbit_q  <= 4'h0;
                    rnz_q   <= 1'b0;
                    rsh_q   <= 9'h000;
                end
            end else if (tick_q) begin
                rph_q <= rph_q + 4'h1;
                if (rph_q == 4'h7) begin
                    smp_q[0] <= rs2_q;
                end
                if (rph_q == 4'h8) begin
                    smp_q[1] <= rs2_q;
                end
                if (rph_q == 4'h9) begin
                    rnz_q <= rnz_q | dis;
                    if (rbit_q == 4'h0) begin
                        rbusy_q <= ~maj; // false start is dropped
                    end else if (rbit_q <= nd) begin
                        rsh_q[rbit_q - 4'h1] <= maj;
                    end else if (rbit_q <= plast) begin
                        rpar_q <= maj;
                    end else begin
                        rbusy_q <= 1'b0;
                        rdone_q <= 1'b1;
                        rfe_q   <= ~maj;
                    end
                end
                if (rph_q == `OVERSAMPLE_LAST) begin
                    rbit_q <= rbit_q + 4'h1;
                end
            end
        end
    end

    // receive fifo: two entries of {parity err, framing err, noise, data}
    reg  [11:0] fifo_q [0:1];
    reg         wp_q;
    reg         rp_q;
    reg  [1:0]  cnt_q;
    wire        parity_error_flag  = ctrl_one_q[`C1_PEN] &
                        ((^(nine ? rsh_q : {1'b0, rsh_q[7:0]})) ^ rpar_q ^ ctrl_one_q[`C1_ODD]);
    wire        abit  = nine ? rsh_q[8] : rsh_q[7];
    wire        keep  = ~ctrl_two_q[`C2_ADEN] | abit;
    wire        full  = (cnt_q == 2'h2);
    wire        push  = rdone_q & keep & ~full & ~status_q[`ST_OVR];
    wire        ovf   = rdone_q & keep & full;
    wire        pop   = rd_dt & (cnt_q != 2'h0);
    wire [11:0] head  = fifo_q[rp_q];
    wire [1:0]  cnt_n = cnt_q + {1'b0, push} - {1'b0, pop};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else if (!rxon) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_n;
        end
    end
    always @(posedge hclk) begin
        if (push) begin
            fifo_q[wp_q] <= {parity_error_flag, rfe_q, rnz_q, rsh_q};
        end
    end
    reg  [7:0]  st_d;
    always @* begin
        st_d = status_q;
        if (wr_dt && armed_q[`ST_TXE]) begin
            st_d[`ST_TXE] = 1'b0;
        end
        if (tload) begin
            st_d[`ST_TXE] = 1'b1;
        end
        if (tbusy_q || thr_full_q || brk_q || wr_dt || brk_go) begin
            st_d[`ST_TIDL] = 1'b0;
        end else if (st_d[`ST_TXE]) begin
            st_d[`ST_TIDL] = 1'b1;
        end
        if (rd_dt) begin
            if (armed_q[`ST_RXA] && cnt_n == 2'h0) begin
                st_d[`ST_RXA] = 1'b0;
            end
            st_d[7:4] = st_d[7:4] & ~armed_q[7:4];
        end
        if (push) begin
            st_d[`ST_RXA] = 1'b1;
            st_d[`ST_NSE] = rnz_q | st_d[`ST_NSE];
            st_d[`ST_FRM] = rfe_q | st_d[`ST_FRM];
            st_d[`ST_PAR] = parity_error_flag | st_d[`ST_PAR];
        end
        if (ovf) begin
            st_d[`ST_OVR] = 1'b1;
        end
        st_d[`ST_RIDL] = ~rbusy_q;
        if (!gen) begin
            st_d = `RST_STATUS;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_one_q <= `RST_CTRL_ONE;
            ctrl_two_q <= `RST_CTRL_TWO;
            divisor_q  <= `RST_DIVISOR;
            status_q   <= `RST_STATUS;
            armed_q    <= 8'h00;
            thr_q      <= 8'h00;
            thr_full_q <= 1'b0;
            addr_q     <= 5'h00;
            wr_q       <= 1'b0;
            hrdata     <= 32'h0000_0000;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            {tx_out, tx_oe_n} <= 2'h3;
            {tx_owned, rx_owned, rx_pullup_off, irq} <= 4'h0;
        end else begin
            status_q <= st_d;
            wr_q     <= acc & hwrite;
            if (acc) begin
                addr_q <= haddr[4:0];
            end
            if (rd_st) begin
                armed_q <= status_q; // status read arms the clear sequences
            end else begin
                if (wr_dt) begin
                    armed_q[1:0] <= 2'h0;
                end
                if (rd_dt) begin
                    armed_q[7:4] <= 4'h0;
                    armed_q[`ST_RXA] <= 1'b0;
                end
            end
            // read data is taken in the address phase so the data phase needs no wait
            hrdata <= 32'h0000_0000;
            if (acc && !hwrite) begin
                case (haddr[4:0])
                    `OFS_STATUS:   hrdata[7:0] <= status_q;
                    `OFS_CTRL_ONE: hrdata[7:0] <= {ctrl_one_q[7:2], head[8], ctrl_one_q[0]};
                    `OFS_CTRL_TWO: hrdata[7:0] <= ctrl_two_q;
                    `OFS_DIVISOR:  hrdata[7:0] <= divisor_q;
                    `OFS_DATA:     hrdata[7:0] <= head[7:0];
                    default:       hrdata[7:0] <= 8'h00;
                endcase
            end
            if (tload || !txon) begin
                thr_full_q <= 1'b0;
            end
            if (wr_q) begin
                case (addr_q)
                    `OFS_CTRL_ONE: begin
                        ctrl_one_q <= {hwdata[7:2], 1'b0, hwdata[0]};
                        if (!hwdata[`C1_GEN]) begin
                            ctrl_one_q[`C1_BRK] <= 1'b0;
                            ctrl_two_q[7:6] <= 2'h0;
                        end
                    end
                    `OFS_CTRL_TWO: begin
                        ctrl_two_q <= hwdata[7:0];
                        if (!gen) begin
                            ctrl_two_q[7:6] <= 2'h0;
                        end
                        if (hwdata[`C2_TRANSMITTER_ENABLE] && !ctrl_two_q[`C2_TRANSMITTER_ENABLE] && gen) begin
                            status_q[`ST_TXE] <= 1'b1;
                        end
                    end
                    `OFS_DIVISOR: divisor_q <= hwdata[7:0];
                    `OFS_DATA: begin
                        if (txon) begin
                            thr_q      <= hwdata[7:0];
                            thr_full_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            tx_owned      <= txon;
            rx_owned      <= rxon;
            rx_pullup_off <= rxon;
            tx_oe_n       <= ~txon;
            tx_out        <= brk_q ? 1'b0 : tsh_q[0];
            irq <= (status_q[`ST_TXE] & ctrl_two_q[`C2_TEIE]) |
                   (status_q[`ST_TIDL] & ctrl_two_q[`C2_TIIE]) |
                   ((status_q[`ST_RXA] | status_q[`ST_OVR]) & ctrl_two_q[`C2_RIE]);
        end
    end
endmodule // async_serial_uart

// ### test/async_serial_uart_chk.sv
// assertions on the serial transceiver's bus outputs and pins
// assumes one hclk domain, hresetn asynchronous active low
`timescale 1ns/10ps
module async_serial_uart_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        tx_out,
    input wire        tx_oe_n,
    input wire        tx_owned,
    input wire        rx_owned,
    input wire        rx_pullup_off
);
    logic wr_q;
    wire  take_w = hsel && htrans[1] && hready && hwrite;
    wire  take_r = hsel && htrans[1] && hready && !hwrite;
    // pin ownership is registered behind the control write, so allow up to three edges
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wr_q <= 1'b0;
        else
            wr_q <= take_w;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_oe_owner: assert property (tx_oe_n != tx_owned)
        else $error("tx enable disagrees with tx ownership");
    a_pullup_off: assert property (rx_pullup_off == rx_owned)
        else $error("rx pull-up state disagrees with rx ownership");
    a_rdata_idle: assert property (!take_r |=> hrdata == 32'h0)
        else $error("read data present without a read");
    a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_start_bit: assert property (disable iff (!hresetn || tx_oe_n)
        $fell(tx_out) |-> !tx_out [*8])
        else $error("start bit shorter than eight clocks");
    a_pin_by_write: assert property (($changed(tx_owned) || $changed(rx_owned))
        |-> ($past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3)))
        else $error("pin ownership changed without a register write");
    a_fall_driven: assert property ($fell(tx_out) |-> !tx_oe_n)
        else $error("tx driven low while not owned");
    c_read: cover property (take_r);
    c_frame: cover property ($fell(tx_out));
    c_owned: cover property (tx_owned && rx_owned);
endmodule // async_serial_uart_chk
bind async_serial_uart async_serial_uart_chk chk_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_out(tx_out), .tx_oe_n(tx_oe_n), .tx_owned(tx_owned), .rx_owned(rx_owned),
    .rx_pullup_off(rx_pullup_off));

// ### test/serial_peer.sv
// far-side serial device: sends frames on rx_line, samples frames seen on tx_line
// assumes the bench clock; one bit lasts bit_len clocks, set by the bench
`timescale 1ns/10ps
module serial_peer (
    input  wire  clk,
    input  wire  tx_line,
    output logic rx_line
);
    int bit_len = 16;
    initial rx_line = 1'b1;
    // g inverts one clock near mid-bit so that only one of the samples disagrees
    task automatic bit_out(input logic b, input logic g);
        rx_line <= b;
        if (g) begin
            repeat (8) @(posedge clk);
            rx_line <= ~b;
            @(posedge clk);
            rx_line <= b;
            repeat (bit_len - 9) @(posedge clk);
        end else
            repeat (bit_len) @(posedge clk);
    endtask
    task automatic send(input logic [8:0] d, input logic n9, pen, odd, bad_stop, input int g);
        int k;
        @(posedge clk);
        bit_out(1'b0, 1'b0);
        for (k = 0; k < 8 + n9; k++)
            bit_out(d[k], g == k + 1);
        if (pen)
            bit_out((^d) ^ odd, 1'b0);
        bit_out(~bad_stop, 1'b0);
        bit_out(1'b1, 1'b0);
        bit_out(1'b1, 1'b0);
    endtask
    task automatic get(output logic [12:0] v);
        int k;
        wait (tx_line === 1'b0);
        repeat (bit_len / 2) @(posedge clk);
        for (k = 0; k < 13; k++) begin
            v[k] = tx_line;
            repeat (bit_len) @(posedge clk);
        end
    endtask
endmodule // serial_peer

// ### test/async_serial_uart_tb_top.sv
// self-checking bench for the serial transceiver over ahb-lite
// assumes the serial peer on the pins and a 40 ns hclk
`timescale 1ns/10ps
`include "serial_defines.vh"
module async_serial_uart_tb_top;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, rx_in, tx_out, tx_oe_n;
    wire         tx_owned, rx_owned, rx_pullup_off, irq;
    int          fail_count = 0;
    int          n_tests = 0;
    always #20 hclk = ~hclk;
    async_serial_uart async_serial_uart_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in),
        .tx_out(tx_out), .tx_oe_n(tx_oe_n), .tx_owned(tx_owned), .rx_owned(rx_owned),
        .rx_pullup_off(rx_pullup_off), .irq(irq));
    serial_peer serial_peer_i (.clk(hclk), .tx_line(tx_out), .rx_line(rx_in));
    task automatic close_out;
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // single word transfer; the master waits on hready, never on a cycle count
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, {24'h0, e}, {24'h0, q});
    endtask
    task automatic t_regs;
        rdc("status reset", `OFS_STATUS, 8'h0B);
        rdc("ctrl1 reset", `OFS_CTRL_ONE, 8'h00);
        rdc("ctrl2 reset", `OFS_CTRL_TWO, 8'h00);
        rdc("unmapped", 5'h1C, 8'h00);
        wr(`OFS_STATUS, 8'hFF);
        wr(5'h1C, 8'hFF);
        rdc("status write", `OFS_STATUS, 8'h0B);
    endtask
    task automatic t_enable;
        wr(`OFS_DIVISOR, 8'h00);
        wr(`OFS_CTRL_ONE, 8'h80);
        repeat (3) @(posedge hclk);
        chk("tx free", 32'h0, {31'h0, tx_owned});
        wr(`OFS_CTRL_TWO, 8'hE4);
        repeat (3) @(posedge hclk);
        chk("pins", 32'hD, {28'h0, tx_owned, rx_owned, tx_oe_n, rx_pullup_off});
        rdc("txe on enable", `OFS_STATUS, 8'h0B);
    endtask
    task automatic t_tx(input logic [8:0] d, input logic n9, pen, odd, two);
        logic [12:0] v;
        logic [12:0] e;
        int k;
        e = 13'h1FFE;
        for (k = 0; k < 8 + n9; k++)
            e[k + 1] = d[k];
        if (pen)
            e[9 + n9] = (^d) ^ odd;
        wr(`OFS_CTRL_ONE, {1'b1, n9, pen, odd, two, 2'b00, d[8]});
        rdc("tx armed", `OFS_STATUS, 8'h0B);
        fork
            serial_peer_i.get(v);
            begin
                wr(`OFS_DATA, d[7:0]);
                repeat (40) @(posedge hclk);
                rdc("tx busy", `OFS_STATUS, 8'h09);
            end
        join
        chk("tx frame", {19'h0, e}, {19'h0, v});
        repeat (20) @(posedge hclk);
        rdc("tx done", `OFS_STATUS, 8'h0B);
    endtask
    task automatic t_rx;
        wr(`OFS_CTRL_ONE, 8'h80);
        fork
            serial_peer_i.send(9'h05A, 1'b0, 1'b0, 1'b0, 1'b0, 0);
            begin
                repeat (60) @(posedge hclk);
                rdc("rx busy", `OFS_STATUS, 8'h03);
            end
        join
        rdc("rx avail", `OFS_STATUS, 8'h0F);
        chk("irq on", 32'h1, {31'h0, irq});
        rdc("rx data", `OFS_DATA, 8'h5A);
        rdc("rx clear", `OFS_STATUS, 8'h0B);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    task automatic t_fifo;
        int k;
        for (k = 1; k < 4; k++)
            serial_peer_i.send(9'h011 * k, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        rdc("overrun", `OFS_STATUS, 8'h1F);
        rdc("fifo first", `OFS_DATA, 8'h11);
        rdc("overrun clear", `OFS_STATUS, 8'h0F);
        rdc("fifo second", `OFS_DATA, 8'h22);
        rdc("fifo empty", `OFS_STATUS, 8'h0B);
    endtask
    task automatic t_err(input logic [7:0] c1, input logic bs, input int g, input logic [7:0] f);
        wr(`OFS_CTRL_ONE, c1);
        serial_peer_i.send(9'h03C, 1'b0, c1[5], 1'b1, bs, g);
        rdc("error flag", `OFS_STATUS, 8'h0F | f);
        rdc("error data", `OFS_DATA, 8'h3C);
        rdc("error clear", `OFS_STATUS, 8'h0B);
    endtask
    task automatic t_break;
        int k;
        int hi;
        wr(`OFS_CTRL_ONE, 8'h84);
        k = 0;
        while (tx_out !== 1'b0 && k < 10) begin
            @(posedge hclk);
            k++;
        end
        hi = 0;
        repeat (215) begin
            @(posedge hclk);
            hi += (tx_out !== 1'b0);
        end
        chk("break held", 32'h0, hi);
        rdc("break busy", `OFS_STATUS, 8'h09);
        wr(`OFS_CTRL_ONE, 8'h80);
        repeat (40) @(posedge hclk);
        chk("break end", 32'h1, {31'h0, tx_out});
    endtask
    task automatic t_off;
        serial_peer_i.send(9'h077, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        wr(`OFS_CTRL_ONE, 8'h00);
        repeat (3) @(posedge hclk);
        rdc("off status", `OFS_STATUS, 8'h0B);
        rdc("off ctrl2", `OFS_CTRL_TWO, 8'h24);
        chk("off pins", 32'h2, {28'h0, tx_owned, rx_owned, tx_oe_n, rx_pullup_off});
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_enable;
        t_tx(9'h0A5, 1'b0, 1'b0, 1'b0, 1'b0);
        t_tx(9'h13C, 1'b1, 1'b1, 1'b1, 1'b1);
        t_tx(9'h05A, 1'b0, 1'b1, 1'b0, 1'b0);
        wr(`OFS_DIVISOR, 8'h01);
        serial_peer_i.bit_len = 32;
        t_tx(9'h0C3, 1'b0, 1'b0, 1'b0, 1'b1);
        serial_peer_i.bit_len = 16;
        wr(`OFS_DIVISOR, 8'h00);
        t_rx;
        t_fifo;
        t_err(8'h80, 1'b1, 0, 8'h20);
        t_err(8'hA0, 1'b0, 0, 8'h80);
        t_err(8'h80, 1'b0, 4, 8'h40);
        t_break;
        t_off;
        close_out;
    end
    // the whole sequence needs about 3200 clocks
    initial begin
        #400000;
        fail_count++;
        close_out;
    end
endmodule // async_serial_uart_tb_top
